// ### ude_pkg.sv
package ude_pkg;
   // ********************************
   // register byte offsets
   // ********************************
   localparam logic [11:0] UDE_CMD_OFS      = 12'h020C;
   localparam logic [11:0] UDE_INT_OFS      = 12'h0220;
   localparam logic [11:0] UDE_EPF_OFS      = 12'h0224;
   localparam logic [11:0] UDE_EPM_OFS      = 12'h0228;
   localparam logic [11:0] UDE_ZLF_OFS      = 12'h022C;
   localparam logic [11:0] UDE_NAKF_OFS     = 12'h0330;
   localparam logic [11:0] UDE_NAKM_OFS     = 12'h0334;
   localparam logic [11:0] UDE_IMSK_OFS     = 12'h0338;
   localparam logic [11:0] UDE_STAT_OFS     = 12'h033C;
   // ********************************
   // interrupt and command register bits
   // ********************************
   localparam int UDE_B_SETUP  = 0;
   localparam int UDE_B_SNAK   = 1;
   localparam int UDE_B_STAT   = 2;
   localparam int UDE_B_ZERO   = 3;
   localparam int UDE_B_SOF    = 4;
   localparam int UDE_B_EP0    = 5;
   localparam int UDE_B_EP     = 6;
   localparam int UDE_B_NAK    = 7;
   localparam int UDE_NFLAG    = 8;
   localparam int UDE_CMD_EPLO = 8;
   localparam int UDE_CMD_SFIN = 4;
   localparam logic [3:0] UDE_CMD_SETUP_FIN = 4'h1;
   // ********************************
   // timing
   // ********************************
   localparam int UDE_CLK_MHZ     = 200;
   localparam int UDE_FS_RST_NS   = 2500;
   localparam int UDE_HS_RST_US   = 3000;
   localparam int UDE_CHIRP_US    = 1500;
   localparam int UDE_CHIRPTO_US  = 2000;
   localparam int UDE_FS_RST_CYC  = (UDE_FS_RST_NS * UDE_CLK_MHZ + 999) / 1000;
   localparam int UDE_HS_RST_CYC  = UDE_HS_RST_US * UDE_CLK_MHZ;
   localparam int UDE_CHIRP_CYC   = UDE_CHIRP_US * UDE_CLK_MHZ;
   localparam int UDE_CHIRPTO_CYC = UDE_CHIRPTO_US * UDE_CLK_MHZ;
   localparam int UDE_HOST_KJ     = 6;
   typedef enum logic [1:0] {UDE_LS_J, UDE_LS_K, UDE_LS_SE0, UDE_LS_SE1} ude_line_t;
endpackage

// ### ude_sync.sv
`timescale 1ns/10ps
module ude_sync
   import ude_pkg::*;
#(
   parameter int W = 2,
   // value of every stage after reset, the idle level of the pins
   parameter logic [W-1:0] INIT = '0
)(
   // clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // pins
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } ude_sync_t;
   ude_sync_t st;
   ude_sync_t next_st;
   always_comb begin
      next_st    = st;
      next_st.s1 = din;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      if (st.s2 == st.s3) begin
         next_st.q = st.s3;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '{s1: INIT, s2: INIT, s3: INIT, q: INIT};
      end else begin
         st <= next_st;
      end
   end
   assign dout = st.q;
endmodule

// ### ude_flags.sv
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
module ude_flags
   import ude_pkg::*;
#(
   parameter int NEP        = 4,
   parameter int HS_RST_CYC = UDE_HS_RST_CYC,
   parameter int CHIRP_CYC  = UDE_CHIRP_CYC,
   parameter int CHIRPTO_CYC = UDE_CHIRPTO_CYC
)(
   // clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // apb slave
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [11:0]      paddr,
   input  wire logic [31:0]      pwdata,
   output logic                  pready,
   output logic      [31:0]      prdata,
   output logic                  pslverr,
   // line state pins (dp, dm)
   input  wire logic [1:0]       line_pins,
   input  wire logic             hs_mode,
   output logic                  chirp_k,
   // protocol events from the packet engine
   input  wire logic             ev_setup,
   input  wire logic             ev_status_tok,
   input  wire logic             ev_status_done,
   input  wire logic             ev_ack,
   input  wire logic             ev_nak,
   input  wire logic             ev_zero,
   input  wire logic             ev_in_data,
   input  wire logic [3:0]       ev_ep,
   input  wire logic             ev_sof,
   // status
   output logic                  bus_reset,
   output logic                  default_state,
   output logic                  status_nak,
   output logic                  irq
);
   typedef enum logic [2:0] {RS_IDLE, RS_FS, RS_CHIRP, RS_WAIT} ude_rst_t;
   typedef struct packed {
      ude_rst_t         rs;
      logic [31:0]      cnt;
      logic [2:0]       kj;
      ude_line_t        last;
      logic             flag;
      logic             dflt;
      logic             setup_done;
      logic [7:0]       intf;
      logic [7:0]       imsk;
      logic [NEP-1:0]   epf;
      logic [NEP-1:0]   epm;
      logic [NEP-1:0]   zlf;
      logic [NEP-1:0]   nakf;
      logic [NEP-1:0]   nakm;
      logic [3:0]       zep;
      logic [31:0]      rd;
      logic             rdy;
   } ude_st_t;
   ude_st_t st;
   ude_st_t next_st;
   logic [1:0] line_q;
   ude_line_t  ls;
   logic       wr;
   logic       rd;
   logic [NEP-1:0] ep_hot;
   logic           set_nak_q;
   logic [31:0]    chirp_len;
   // ********************************
   // pin synchroniser
   // ********************************
   // reset to idle J so no false SE0 run follows reset
   ude_sync #(.W(2), .INIT(2'b10)) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .din     (line_pins),
      .dout    (line_q)
   );
   always_comb begin
      unique case (line_q)
         2'b10:   ls = UDE_LS_J;
         2'b01:   ls = UDE_LS_K;
         2'b00:   ls = UDE_LS_SE0;
         default: ls = UDE_LS_SE1;
      endcase
   end
   function automatic logic [NEP-1:0] clr_bits(input logic [NEP-1:0] cur,
                                                input logic [NEP-1:0] set,
                                                input logic [NEP-1:0] w1c);
      clr_bits = (cur & ~w1c) | set;
   endfunction
   function automatic logic [NEP-1:0] onehot(input logic [3:0] ep);
      onehot = '0;
      onehot[ep[$clog2(NEP)-1:0]] = 1'b1;
   endfunction
   assign wr     = psel && penable && pwrite && st.rdy;
   assign rd     = psel && !penable && !pwrite;
   assign ep_hot = onehot(ev_ep);
   // ********************************
   // next state
   // ********************************
   always_comb begin
      logic [7:0]     set;
      logic [7:0]     w1c;
      logic [NEP-1:0] wep;
      logic           ep0;
      set = '0;
      w1c = '0;
      wep = pwdata[NEP-1:0];
      ep0 = (ev_ep == 4'h0);
      next_st = st;
      next_st.rdy = psel && !penable;
      next_st.last = ls;
      // bus reset detection
      unique case (st.rs)
         RS_IDLE: begin
            next_st.cnt = (ls == UDE_LS_SE0) ? st.cnt + 32'h0000_0001 : '0;
            if (!hs_mode && st.cnt >= 32'(UDE_FS_RST_CYC - 1) && ls == UDE_LS_SE0) begin
               next_st.rs = RS_FS;
            end
            // idle J in high speed means suspend; only SE0 for full time is reset
            if (hs_mode && st.cnt >= 32'(HS_RST_CYC - 1) && ls == UDE_LS_SE0) begin
               next_st.rs  = RS_CHIRP;
               next_st.cnt = '0;
            end
         end
         RS_FS: begin
            if (ls != UDE_LS_SE0) begin
               next_st.rs  = RS_IDLE;
               next_st.cnt = '0;
            end
         end
         RS_CHIRP: begin
            next_st.cnt = st.cnt + 32'h0000_0001;
            if (st.cnt >= 32'(CHIRP_CYC - 1)) begin
               next_st.rs  = RS_WAIT;
               next_st.cnt = '0;
               next_st.kj  = '0;
            end
         end
         RS_WAIT: begin
            next_st.cnt = st.cnt + 32'h0000_0001;
            if ((ls == UDE_LS_K || ls == UDE_LS_J) && ls != st.last) begin
               next_st.kj = st.kj + 3'd1;
            end
            if (st.kj >= 3'(UDE_HOST_KJ) || st.cnt >= 32'(CHIRPTO_CYC - 1)) begin
               next_st.rs  = RS_IDLE;
               next_st.cnt = '0;
            end
         end
         default: next_st.rs = RS_IDLE;
      endcase
      next_st.flag = (next_st.rs != RS_IDLE);
      if (next_st.flag) begin
         next_st.dflt       = 1'b1;
         next_st.setup_done = 1'b0;
      end else if (ev_setup) begin
         next_st.dflt = 1'b0;
      end
      // protocol events
      if (ev_setup) begin
         set[UDE_B_SETUP]   = 1'b1;
         next_st.setup_done = 1'b0;
      end
      if (ev_status_tok && !st.setup_done) begin
         set[UDE_B_SNAK] = 1'b1;
      end
      if (ev_status_done) begin
         set[UDE_B_STAT] = 1'b1;
      end
      if (ev_ack && ep0) begin
         set[UDE_B_EP0] = 1'b1;
      end
      if (ev_ack && !ep0 && |(ep_hot & ~st.epm)) begin
         set[UDE_B_EP] = 1'b1;
      end
      // only zero-length packets received count, not ones sent
      if (ev_zero && !ev_in_data && !(ep0 && ev_status_tok)) begin
         set[UDE_B_ZERO] = 1'b1;
         next_st.zep     = ev_ep;
      end
      if (ev_sof) begin
         set[UDE_B_SOF] = 1'b1;
      end
      if (ev_nak && !ep0 && |(ep_hot & ~st.nakm)) begin
         set[UDE_B_NAK] = 1'b1;
      end
      // register writes
      if (wr && paddr == UDE_INT_OFS) begin
         w1c = pwdata[7:0];
      end
      if (wr && paddr == UDE_CMD_OFS &&
          pwdata[UDE_CMD_SFIN-1:0] == UDE_CMD_SETUP_FIN) begin
         next_st.setup_done = 1'b1;
      end
      next_st.epf  = clr_bits(st.epf, (ev_ack && !ep0) ? ep_hot : '0,
                              (wr && paddr == UDE_EPF_OFS) ? wep : '0);
      next_st.zlf  = clr_bits(st.zlf, set[UDE_B_ZERO] ? ep_hot : '0,
                              (wr && paddr == UDE_ZLF_OFS) ? wep : '0);
      next_st.nakf = clr_bits(st.nakf, (ev_nak && !ep0) ? ep_hot : '0,
                              (wr && paddr == UDE_NAKF_OFS) ? wep : '0);
      // writing ones to every set endpoint bit also drops the summary flag
      if (wr && paddr == UDE_EPF_OFS && (st.epf & ~wep) == '0) begin
         w1c[UDE_B_EP] = 1'b1;
      end
      if (wr && paddr == UDE_ZLF_OFS && (st.zlf & ~wep) == '0) begin
         w1c[UDE_B_ZERO] = 1'b1;
      end
      if (wr && paddr == UDE_NAKF_OFS && (st.nakf & ~wep) == '0) begin
         w1c[UDE_B_NAK] = 1'b1;
      end
      next_st.intf = (st.intf & ~w1c) | set;
      if (wr && paddr == UDE_EPM_OFS) begin
         next_st.epm = wep;
      end
      if (wr && paddr == UDE_NAKM_OFS) begin
         next_st.nakm = wep;
      end
      if (wr && paddr == UDE_IMSK_OFS) begin
         next_st.imsk = pwdata[7:0];
      end
      // read data captured in setup cycle
      if (rd) begin
         next_st.rd = '0;
         unique case (paddr)
            UDE_CMD_OFS:  next_st.rd[UDE_CMD_EPLO +: 4] = st.zep;
            UDE_INT_OFS:  next_st.rd[7:0] = st.intf;
            UDE_EPF_OFS:  next_st.rd[NEP-1:0] = st.epf;
            UDE_EPM_OFS:  next_st.rd[NEP-1:0] = st.epm;
            UDE_ZLF_OFS:  next_st.rd[NEP-1:0] = st.zlf;
            UDE_NAKF_OFS: next_st.rd[NEP-1:0] = st.nakf;
            UDE_NAKM_OFS: next_st.rd[NEP-1:0] = st.nakm;
            UDE_IMSK_OFS: next_st.rd[7:0] = st.imsk;
            UDE_STAT_OFS: next_st.rd[2:0] = {st.setup_done, st.dflt, st.flag};
            default:      next_st.rd = '0;
         endcase
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st      <= '0;
         st.rs   <= RS_IDLE;
         st.last <= UDE_LS_J;
         st.dflt <= 1'b1;
         st.nakm <= '1;
         st.imsk <= '1;
      end else begin
         st <= next_st;
      end
   end
   assign pready        = st.rdy;
   assign prdata        = st.rd;
   assign pslverr       = 1'b0;
   assign chirp_k       = (st.rs == RS_CHIRP);
   assign bus_reset     = st.flag;
   assign default_state = st.dflt;
   assign status_nak    = set_nak_q;
   assign irq           = |(st.intf & ~st.imsk);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         set_nak_q <= 1'b0;
      end else begin
         set_nak_q <= ev_status_tok && !st.setup_done;
      end
   end
   // ********************************
   // checks
   // ********************************
   property p_setup_flag;
      @(posedge pclk) disable iff (!presetn) ev_setup |=> st.intf[UDE_B_SETUP];
   endproperty
   a_setup_flag: assert property (p_setup_flag) else $error("setup flag not set");
   property p_set_wins;
      @(posedge pclk) disable iff (!presetn)
         (ev_sof && wr && paddr == UDE_INT_OFS) |=> st.intf[UDE_B_SOF];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("set lost to clear");
   // cycles of chirp k so far, checked where it ends
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chirp_len <= '0;
      end else begin
         chirp_len <= chirp_k ? chirp_len + 32'h0000_0001 : '0;
      end
   end
   property p_chirp_len;
      @(posedge pclk) disable iff (!presetn)
         $fell(chirp_k) |-> chirp_len == 32'(CHIRP_CYC);
   endproperty
   a_chirp_len: assert property (p_chirp_len) else $error("chirp too short");
   property p_reset_dflt;
      @(posedge pclk) disable iff (!presetn) bus_reset |-> default_state;
   endproperty
   a_reset_dflt: assert property (p_reset_dflt) else $error("not default in reset");
   property p_nak_mask;
      @(posedge pclk) disable iff (!presetn)
         (ev_nak && (ep_hot & ~st.nakm) == '0 && !st.intf[UDE_B_NAK]) |=> !st.intf[UDE_B_NAK];
   endproperty
   a_nak_mask: assert property (p_nak_mask) else $error("masked nak flagged");
   property p_sof;
      @(posedge pclk) disable iff (!presetn) ev_sof |=> irq || st.imsk[UDE_B_SOF];
   endproperty
   a_sof: assert property (p_sof) else $error("sof missing");
   property p_ep0;
      @(posedge pclk) disable iff (!presetn) (ev_ack && ev_ep == 4'h0) |=> st.intf[UDE_B_EP0];
   endproperty
   a_ep0: assert property (p_ep0) else $error("ep0 flag missing");
   property p_stat;
      @(posedge pclk) disable iff (!presetn) ev_status_done |=> st.intf[UDE_B_STAT];
   endproperty
   a_stat: assert property (p_stat) else $error("status flag missing");
   property p_status_nak;
      @(posedge pclk) disable iff (!presetn)
         (ev_status_tok && !st.setup_done) |=> status_nak && st.intf[UDE_B_SNAK];
   endproperty
   a_status_nak: assert property (p_status_nak) else $error("status nak missing");
   property p_zero_status;
      @(posedge pclk) disable iff (!presetn)
         (ev_zero && ev_status_tok && ev_ep == 4'h0 && !st.intf[UDE_B_ZERO])
            |=> !st.intf[UDE_B_ZERO];
   endproperty
   a_zero_status: assert property (p_zero_status) else $error("status zero flagged");
endmodule

// ### ude_host.sv
`timescale 1ns/10ps
module ude_host
   import ude_pkg::*;
(
   // clock
   input  wire logic       pclk,
   // bus lines {dp, dm}
   output logic      [1:0] line_pins
);
   // ****************************************
   // line state driver
   // ****************************************
   initial begin
      line_pins = 2'b10;
   end
   // hold one line state for n clocks
   task automatic drive(input logic [1:0] st, input int n);
      line_pins <= st;
      repeat (n) @(posedge pclk);
   endtask
   // host chirp k-j-k-j-k-j, then idle j
   task automatic chirp(input int n);
      for (int i = 0; i < UDE_HOST_KJ; i++) begin
         drive((i % 2) ? 2'b10 : 2'b01, n);
      end
      line_pins <= 2'b10;
   endtask
endmodule

// ### usb_device_event_flags_tb_top.sv
`timescale 1ns/10ps
module usb_device_event_flags_tb_top
   import ude_pkg::*;
;
   localparam int HS = 50;
   localparam int CH = 30;
   localparam int TO = 40;
   logic        pclk, presetn, psel, penable, pwrite, hs_mode, snak;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, chirp_k, bus_reset, default_state, status_nak, irq;
   // 0 setup 1 status_tok 2 status_done 3 ack 4 nak 5 zero 6 in_data 7 sof
   logic [7:0]  evs;
   logic [3:0]  ev_ep;
   wire  [1:0]  line_pins;
   int          fails, check_count;

   ude_host u_host (.pclk(pclk), .line_pins(line_pins));
   ude_flags #(.NEP(4), .HS_RST_CYC(HS), .CHIRP_CYC(CH), .CHIRPTO_CYC(TO)) u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .line_pins(line_pins), .hs_mode(hs_mode), .chirp_k(chirp_k),
      .ev_setup(evs[0]), .ev_status_tok(evs[1]), .ev_status_done(evs[2]),
      .ev_ack(evs[3]), .ev_nak(evs[4]), .ev_zero(evs[5]), .ev_in_data(evs[6]),
      .ev_ep(ev_ep), .ev_sof(evs[7]), .bus_reset(bus_reset),
      .default_state(default_state), .status_nak(status_nak), .irq(irq));

   // ****************************************
   // helpers
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      chk(pslverr, 0, "slave error");
      if (n >= 20) chk(0, 1, "apb timeout");
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string m);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, e, m);
   endtask
   task automatic pulse(input logic [7:0] v, input logic [3:0] ep);
      @(posedge pclk);
      evs   <= v;
      ev_ep <= ep;
      @(posedge pclk);
      evs   <= 8'h00;
      #1 snak = status_nak;
   endtask
   // wait for bus_reset (s=0) or chirp_k (s=1) to reach v
   task automatic wait_sig(input bit s, input logic v, input int max, input string m);
      int n;
      n = 0;
      // look on the falling edge, where outputs have settled
      @(negedge pclk);
      while ((s ? chirp_k : bus_reset) !== v && n < max) begin
         @(negedge pclk);
         n++;
      end
      @(posedge pclk);
      chk(32'(n < max), 1, m);
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset_vals;
      rdc(UDE_INT_OFS, 32'h0000_0000, "int after reset");
      rdc(UDE_NAKM_OFS, 32'h0000_000F, "nak mask after reset");
      rdc(12'h100, 32'h0000_0000, "unmapped read");
      rdc(UDE_STAT_OFS, 32'h0000_0002, "status after reset");
      chk(default_state, 1, "default state after reset");
   endtask
   task automatic t_fs_reset;
      u_host.drive(2'b00, 400);
      chk(bus_reset, 0, "fs reset too early");
      wait_sig(0, 1'b1, 130, "fs reset not raised");
      u_host.drive(2'b00, 50);
      chk(bus_reset, 1, "reset flag dropped during se0");
      chk(default_state, 1, "not default on reset");
      u_host.drive(2'b10, 1);
      wait_sig(0, 1'b0, 20, "fs reset not released");
   endtask
   task automatic t_hs_reset(input bit host_chirps);
      hs_mode <= 1'b1;
      u_host.drive(2'b00, HS - 10);
      chk(bus_reset, 0, "hs reset too early");
      wait_sig(0, 1'b1, 40, "hs reset not raised");
      wait_sig(1, 1'b1, 10, "chirp k not driven");
      wait_sig(1, 1'b0, CH + 10, "chirp k not ended");
      chk(bus_reset, 1, "flag dropped during chirp");
      if (host_chirps) begin
         u_host.chirp(4);
         // limit well below the timeout, so only the host chirp can end it
         wait_sig(0, 1'b0, 8, "flag kept after host chirp");
      end else begin
         u_host.drive(2'b10, 1);
         wait_sig(0, 1'b0, TO + 20, "flag kept after timeout");
      end
      hs_mode <= 1'b0;
   endtask
   task automatic t_control;
      pulse(8'h01, 4'h0);
      rdc(UDE_INT_OFS, 32'h0000_0001, "setup flag");
      rdc(UDE_STAT_OFS, 32'h0000_0000, "still default after setup");
      wr(UDE_INT_OFS, 32'h0000_0000);
      rdc(UDE_INT_OFS, 32'h0000_0001, "write zero cleared flag");
      pulse(8'h02, 4'h0);
      chk(snak, 1, "status nak not pulsed");
      rdc(UDE_INT_OFS, 32'h0000_0003, "status nak flag");
      wr(UDE_INT_OFS, 32'h0000_0003);
      rdc(UDE_INT_OFS, 32'h0000_0000, "setup and nak not cleared");
      wr(UDE_CMD_OFS, 32'h0000_0001);
      pulse(8'h02, 4'h0);
      chk(snak, 0, "nak after setup finish");
      pulse(8'h04, 4'h0);
      rdc(UDE_INT_OFS, 32'h0000_0004, "status done flag");
      wr(UDE_INT_OFS, 32'h0000_0004);
      pulse(8'h08, 4'h0);
      rdc(UDE_INT_OFS, 32'h0000_0020, "ep0 ack flag");
      wr(UDE_INT_OFS, 32'h0000_0020);
      rdc(UDE_INT_OFS, 32'h0000_0000, "ep0 flag not cleared");
   endtask
   task automatic t_endpoints;
      wr(UDE_EPM_OFS, 32'h0000_0000);
      pulse(8'h08, 4'h2);
      rdc(UDE_INT_OFS, 32'h0000_0040, "endpoint flag");
      rdc(UDE_EPF_OFS, 32'h0000_0004, "endpoint bit");
      wr(UDE_EPF_OFS, 32'h0000_0004);
      rdc(UDE_INT_OFS, 32'h0000_0000, "endpoint flag kept");
      pulse(8'h20, 4'h3);
      rdc(UDE_INT_OFS, 32'h0000_0008, "zero length flag");
      apb(1'b0, UDE_CMD_OFS, 32'h0000_0000);
      chk(32'(rd[11:8]), 3, "zero length endpoint number");
      rdc(UDE_ZLF_OFS, 32'h0000_0008, "zero length endpoint bit");
      wr(UDE_ZLF_OFS, 32'h0000_0008);
      rdc(UDE_INT_OFS, 32'h0000_0000, "zero length flag kept");
      pulse(8'h60, 4'h3);
      rdc(UDE_INT_OFS, 32'h0000_0000, "zero length sent raised flag");
      pulse(8'h22, 4'h0);
      rdc(UDE_INT_OFS, 32'h0000_0000, "zero length in status stage");
      pulse(8'h80, 4'h0);
      rdc(UDE_INT_OFS, 32'h0000_0010, "sof flag");
      wr(UDE_INT_OFS, 32'h0000_0010);
      pulse(8'h10, 4'h1);
      rdc(UDE_INT_OFS, 32'h0000_0000, "masked nak raised flag");
      wr(UDE_NAKM_OFS, 32'h0000_000D);
      pulse(8'h10, 4'h1);
      rdc(UDE_INT_OFS, 32'h0000_0080, "nak flag");
      rdc(UDE_NAKF_OFS, 32'h0000_0002, "nak endpoint bit");
      wr(UDE_NAKF_OFS, 32'h0000_0002);
      rdc(UDE_INT_OFS, 32'h0000_0000, "nak flag kept");
   endtask
   task automatic t_irq;
      pulse(8'h01, 4'h0);
      #1 chk(irq, 0, "irq while masked");
      wr(UDE_INT_OFS, 32'h0000_0001);
      wr(UDE_IMSK_OFS, 32'hFFFF_FFEF);
      fork
         wr(UDE_INT_OFS, 32'h0000_0010);
         begin
            @(posedge pclk);
            pulse(8'h80, 4'h0);
         end
      join
      rdc(UDE_INT_OFS, 32'h0000_0010, "set lost to clear");
      #1 chk(irq, 1, "irq not raised");
      wr(UDE_INT_OFS, 32'h0000_0010);
      #1 chk(irq, 0, "irq not cleared");
   endtask

   // ****************************************
   // run control
   // ****************************************
   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   initial begin
      repeat (20000) @(posedge pclk);
      fails++;
      final_report();
   end
   initial begin
      {presetn, psel, penable, pwrite, hs_mode} = 5'b0;
      {paddr, pwdata, evs, ev_ep} = '0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_reset_vals();
      t_fs_reset();
      t_hs_reset(1'b1);
      t_hs_reset(1'b0);
      t_control();
      t_endpoints();
      t_irq();
      final_report();
   end
endmodule
